// ### design/ddsc_defs.vh
// Constants for the clock divider and synthesizer core
`ifndef DDSC_DEFS_VH
`define DDSC_DEFS_VH
`define DDSC_ACC_W       48
`define DDSC_POFF_W      14
`define DDSC_DAC_W       10
`define DDSC_LUT_AW      8
`define DDSC_NPROF       8
`define DDSC_RDIV_1      2'h0
`define DDSC_RDIV_2      2'h1
`define DDSC_RDIV_4      2'h2
`define DDSC_RDIV_8      2'h3
`define DDSC_SRC_RF      2'h0
`define DDSC_SRC_RDIV    2'h1
`define DDSC_SRC_FB      2'h2
`define DDSC_DAC_MID     10'h200
`define DDSC_FTW_MAX     48'h800000000000
`define DDSC_SYNC_DIV_W  2
`endif

// ### design/ddsc_cos_lut.v
// Cosine phase-to-amplitude table, offset binary converter code
`timescale 1ns/1ps
`default_nettype none
`include "ddsc_defs.vh"
module ddsc_cos_lut (
	// Clock
	input  wire                        mclk,
	input  wire                        nrst,
	input  wire                        ce,
	// Phase in, code out
	input  wire [`DDSC_LUT_AW+1:0]     phase,
	output reg  [`DDSC_DAC_W-1:0]      code_q
);
	reg  [`DDSC_DAC_W-2:0] rom [0:(1<<`DDSC_LUT_AW)-1];
	reg  [`DDSC_LUT_AW-1:0] idx;
	reg  [`DDSC_DAC_W-2:0]  mag;
	reg  [`DDSC_DAC_W-1:0]  code_d;
	integer i;
	integer amp;
	// Quarter wave of 511*cos, built once at elaboration
	initial begin
		for (i = 0; i < (1 << `DDSC_LUT_AW); i = i + 1) begin
			amp = $rtoi(511.0 * $cos(3.14159265358979 *
				(i + 0.5) / 512.0) + 0.5);
			rom[i] = amp[`DDSC_DAC_W-2:0];
		end
	end
	// Quadrant fold, midscale splits current equally
	always @* begin
		idx = phase[`DDSC_LUT_AW] ? ~phase[`DDSC_LUT_AW-1:0] :
			phase[`DDSC_LUT_AW-1:0];
		mag = rom[idx];
		if (phase[`DDSC_LUT_AW+1] ^ phase[`DDSC_LUT_AW])
			code_d = `DDSC_DAC_MID - {1'b0, mag} - 10'h001;
		else
			code_d = `DDSC_DAC_MID + {1'b0, mag};
	end
	always @(posedge mclk or negedge nrst) begin
		if (!nrst)
			code_q <= `DDSC_DAC_MID;
		else if (ce)
			code_q <= code_d;
	end
endmodule // ddsc_cos_lut
`default_nettype wire

// ### design/ddsc_core.v
// Divider control, clock routing and phase accumulator synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "ddsc_defs.vh"
module ddsc_core (
	// Clock and reset
	input  wire                        mclk,
	input  wire                        nrst,
	input  wire                        ce,
	// Buffered configuration
	input  wire [1:0]                  rdiv_sel,
	input  wire                        rdiv_to_driver,
	input  wire [3:0]                  ref_div_m1,
	input  wire [3:0]                  fb_div_m1,
	input  wire [2:0]                  second_control_word,
	input  wire [1:0]                  driver_src_sel,
	input  wire                        surge_rise_en,
	input  wire                        surge_fall_en,
	input  wire                        surge_dflt_dis,
	input  wire                        drv_int_rset,
	input  wire                        xtal_osc_en,
	// Profile write port
	input  wire                        prof_we,
	input  wire [2:0]                  prof_waddr,
	input  wire [`DDSC_ACC_W-1:0]      prof_ftw,
	input  wire [`DDSC_POFF_W-1:0]     prof_poff,
	// Pins
	input  wire [2:0]                  profile_select_pins,
	input  wire                        io_update,
	input  wire                        rf_clock_input,
	input  wire                        feedback_clock_input,
	input  wire                        reference_clock_input,
	// Active controls
	output reg  [1:0]                  rdiv_ratio_q,
	output reg                         rdiv_to_driver_q,
	output reg  [3:0]                  ref_div_q,
	output reg  [3:0]                  fb_div_q,
	output reg  [2:0]                  pump_scale_q,
	output reg  [1:0]                  driver_src_q,
	output reg                         surge_rise_q,
	output reg                         surge_fall_q,
	output reg                         surge_dflt_dis_q,
	output reg                         drv_int_rset_q,
	output reg                         xtal_osc_q,
	// Divided clocks
	output reg                         rf_div_clk_q,
	output reg                         ref_div_clk_q,
	output reg                         fb_div_clk_q,
	output reg                         driver_clk_q,
	output reg                         sync_clk_q,
	// Converter code
	output wire [`DDSC_DAC_W-1:0]      converter_current_output
);
	// Profile store and active copy
	reg  [`DDSC_ACC_W-1:0]  ftw_mem  [0:`DDSC_NPROF-1];
	reg  [`DDSC_POFF_W-1:0] poff_mem [0:`DDSC_NPROF-1];
	reg  [`DDSC_ACC_W-1:0]  ftw_q;
	reg  [`DDSC_POFF_W-1:0] poff_q;
	reg  [`DDSC_ACC_W-1:0]  acc_q;
	reg  [`DDSC_POFF_W-1:0] phase_q;
	reg  [`DDSC_SYNC_DIV_W-1:0] sync_cnt_q;
	reg  [2:0]              rf_cnt_q;
	reg  [3:0]              ref_cnt_q;
	reg  [3:0]              fb_cnt_q;
	reg  [1:0]              rf_s_q, fb_s_q, ref_s_q, upd_s_q;
	reg  [5:0]              sel_s_q;
	reg                     upd_pend_q;
	reg                     rf_last_q, fb_last_q, ref_last_q;
	wire                    rf_s, fb_s, ref_s, upd_s;
	wire [2:0]              sel_s;
	wire                    sync_edge;
	wire                    rf_rise, fb_rise, ref_rise;
	wire [`DDSC_ACC_W-1:0]  ftw_lim;
	reg                     rf_div_d;
	reg                     drv_d;
	integer k;
	assign rf_s  = rf_s_q[1];
	assign fb_s  = fb_s_q[1];
	assign ref_s = ref_s_q[1];
	assign upd_s = upd_s_q[1];
	assign sel_s = sel_s_q[5:3];
	assign rf_rise  = rf_s & ~rf_last_q;
	assign fb_rise  = fb_s & ~fb_last_q;
	assign ref_rise = ref_s & ~ref_last_q;
	assign sync_edge = (sync_cnt_q == 2'h3);
	// Words above half range alias, clamp to the top valid word
	assign ftw_lim = (ftw_q > `DDSC_FTW_MAX) ? `DDSC_FTW_MAX : ftw_q;

	// Pin synchronisers
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rf_s_q  <= 2'h0;
			fb_s_q  <= 2'h0;
			ref_s_q <= 2'h0;
			upd_s_q <= 2'h0;
			sel_s_q <= 6'h00;
			rf_last_q  <= 1'b0;
			fb_last_q  <= 1'b0;
			ref_last_q <= 1'b0;
		end else if (ce) begin
			rf_s_q  <= {rf_s_q[0], rf_clock_input};
			fb_s_q  <= {fb_s_q[0], feedback_clock_input};
			ref_s_q <= {ref_s_q[0], reference_clock_input};
			upd_s_q <= {upd_s_q[0], io_update};
			sel_s_q <= {sel_s_q[2:0], profile_select_pins};
			rf_last_q  <= rf_s;
			fb_last_q  <= fb_s;
			ref_last_q <= ref_s;
		end
	end

	// Profile memory writes
	always @(posedge mclk) begin
		if (ce && prof_we) begin
			ftw_mem[prof_waddr]  <= prof_ftw;
			poff_mem[prof_waddr] <= prof_poff;
		end
	end

	// Sync clock divider and update transfer
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sync_cnt_q <= 2'h0;
			sync_clk_q <= 1'b0;
			upd_pend_q <= 1'b0;
			rdiv_ratio_q     <= `DDSC_RDIV_1;
			rdiv_to_driver_q <= 1'b1;
			ref_div_q        <= 4'h0;
			fb_div_q         <= 4'h0;
			pump_scale_q     <= 3'h0;
			driver_src_q     <= `DDSC_SRC_RDIV;
			surge_rise_q     <= 1'b0;
			surge_fall_q     <= 1'b0;
			surge_dflt_dis_q <= 1'b0;
			drv_int_rset_q   <= 1'b0;
			xtal_osc_q       <= 1'b0;
		end else if (ce) begin
			sync_cnt_q <= sync_cnt_q + 2'h1;
			sync_clk_q <= sync_cnt_q[1];
			if (sync_edge) begin
				upd_pend_q <= 1'b0;
				if (upd_s || upd_pend_q) begin
					rdiv_ratio_q     <= rdiv_sel;
					rdiv_to_driver_q <= rdiv_to_driver;
					ref_div_q        <= ref_div_m1;
					fb_div_q         <= fb_div_m1;
					pump_scale_q     <= second_control_word;
					driver_src_q     <= driver_src_sel;
					surge_rise_q     <= surge_rise_en;
					surge_fall_q     <= surge_fall_en;
					surge_dflt_dis_q <= surge_dflt_dis;
					drv_int_rset_q   <= drv_int_rset;
					xtal_osc_q       <= xtal_osc_en;
				end
			end else if (upd_s) begin
				upd_pend_q <= 1'b1;
			end
		end
	end

	// Clock dividers on sampled inputs
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rf_cnt_q      <= 3'h0;
			ref_cnt_q     <= 4'h0;
			fb_cnt_q      <= 4'h0;
			rf_div_clk_q  <= 1'b0;
			ref_div_clk_q <= 1'b0;
			fb_div_clk_q  <= 1'b0;
			driver_clk_q  <= 1'b0;
		end else if (ce) begin
			if (rf_rise)
				rf_cnt_q <= rf_cnt_q + 3'h1;
			// Ratio one passes the sampled input straight on
			if (ref_div_q == 4'h0) begin
				ref_cnt_q     <= 4'h0;
				ref_div_clk_q <= ref_s;
			end else if (ref_rise) begin
				if (ref_cnt_q >= ref_div_q) begin
					ref_cnt_q     <= 4'h0;
					ref_div_clk_q <= 1'b1;
				end else begin
					ref_cnt_q     <= ref_cnt_q + 4'h1;
					ref_div_clk_q <= 1'b0;
				end
			end
			if (fb_div_q == 4'h0) begin
				fb_cnt_q     <= 4'h0;
				fb_div_clk_q <= fb_s;
			end else if (fb_rise) begin
				if (fb_cnt_q >= fb_div_q) begin
					fb_cnt_q     <= 4'h0;
					fb_div_clk_q <= 1'b1;
				end else begin
					fb_cnt_q     <= fb_cnt_q + 4'h1;
					fb_div_clk_q <= 1'b0;
				end
			end
			rf_div_clk_q <= rf_div_d;
			driver_clk_q <= drv_d;
		end
	end

	// Divider tap and driver source mux
	always @* begin
		case (rdiv_ratio_q)
		`DDSC_RDIV_2: rf_div_d = rf_cnt_q[0];
		`DDSC_RDIV_4: rf_div_d = rf_cnt_q[1];
		`DDSC_RDIV_8: rf_div_d = rf_cnt_q[2];
		default:      rf_div_d = rf_s;
		endcase
		case (driver_src_q)
		`DDSC_SRC_RF:   drv_d = rf_s;
		`DDSC_SRC_RDIV: drv_d = rdiv_to_driver_q ? rf_div_d : rf_s;
		`DDSC_SRC_FB:   drv_d = fb_s;
		default:        drv_d = 1'b0;
		endcase
	end

	// Accumulator and phase offset
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ftw_q   <= {`DDSC_ACC_W{1'b0}};
			poff_q  <= {`DDSC_POFF_W{1'b0}};
			acc_q   <= {`DDSC_ACC_W{1'b0}};
			phase_q <= {`DDSC_POFF_W{1'b0}};
		end else if (ce) begin
			if (sync_edge && (upd_s || upd_pend_q)) begin
				for (k = 0; k < `DDSC_NPROF; k = k + 1) begin
					if (sel_s == k[2:0]) begin
						ftw_q  <= ftw_mem[k];
						poff_q <= poff_mem[k];
					end
				end
			end
			acc_q <= acc_q + ftw_lim;
			phase_q <= acc_q[`DDSC_ACC_W-1:`DDSC_ACC_W-`DDSC_POFF_W]
				+ poff_q;
		end
	end

	// Cosine map, registered code every cycle
	ddsc_cos_lut u_lut (
		.mclk   (mclk),
		.nrst   (nrst),
		.ce     (ce),
		.phase  (phase_q[`DDSC_POFF_W-1:`DDSC_POFF_W-`DDSC_LUT_AW-2]),
		.code_q (converter_current_output)
	);
endmodule // ddsc_core
`default_nettype wire

// ### tb/ddsc_chk_checker.sv
// Assertion checker for the clock divider and synthesizer core
`timescale 1ns/1ps
`default_nettype none
module ddsc_chk (
	// Clock, reset and strobe
	input wire logic       mclk,
	input wire logic       nrst,
	input wire logic       io_update,
	// Buffered fields
	input wire logic [1:0] rdiv_sel,
	input wire logic       rdiv_to_driver,
	input wire logic [3:0] ref_div_m1,
	input wire logic [3:0] fb_div_m1,
	input wire logic [2:0] second_control_word,
	input wire logic [1:0] driver_src_sel,
	// Active fields and clocks
	input wire logic [1:0] rdiv_ratio_q,
	input wire logic       rdiv_to_driver_q,
	input wire logic [3:0] ref_div_q,
	input wire logic [3:0] fb_div_q,
	input wire logic [2:0] pump_scale_q,
	input wire logic [1:0] driver_src_q,
	input wire logic       driver_clk_q,
	input wire logic       sync_clk_q,
	input wire logic [9:0] converter_current_output
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	AST_RDIV: assert property ((io_update && $stable(rdiv_sel))[*8]
		|=> rdiv_ratio_q == $past(rdiv_sel)) else $error("ratio not loaded");
	AST_ROUTE: assert property ((io_update && $stable(rdiv_to_driver))[*8]
		|=> rdiv_to_driver_q == $past(rdiv_to_driver)) else $error("route");
	AST_REFDIV: assert property ((io_update && $stable(ref_div_m1))[*8]
		|=> ref_div_q == $past(ref_div_m1)) else $error("ref divider");
	AST_FBDIV: assert property ((io_update && $stable(fb_div_m1))[*8]
		|=> fb_div_q == $past(fb_div_m1)) else $error("fb divider");
	AST_PUMP: assert property ((io_update && $stable(second_control_word))[*8]
		|=> pump_scale_q == $past(second_control_word)) else $error("pump");
	AST_SRC: assert property ((io_update && $stable(driver_src_sel))[*8]
		|=> driver_src_q == $past(driver_src_sel)) else $error("source");
	AST_OFF: assert property ((driver_src_q == 2'h3)[*3]
		|-> !driver_clk_q) else $error("driver not low when off");
	AST_HOLD: assert property ((!io_update)[*8] |=> $stable({rdiv_ratio_q,
		rdiv_to_driver_q, ref_div_q, fb_div_q, pump_scale_q, driver_src_q}))
		else $error("actives changed without update");
	AST_SYNC: assert property ($rose(sync_clk_q)
		|=> (!$rose(sync_clk_q))[*3] ##1 $rose(sync_clk_q))
		else $error("sync clock period");
	AST_MID: assert property (disable iff (1'b0) !nrst
		|-> converter_current_output == 10'h200) else $error("not midscale");
endmodule // ddsc_chk
`default_nettype wire

// ### tb/ddsc_far.sv
// Behavioural far-side clock sources: RF, feedback and reference
`timescale 1ns/1ps
`default_nettype none
module ddsc_far (
	// Clocks toward the core
	output var logic rf_clock_input,
	output var logic feedback_clock_input,
	output var logic reference_clock_input
);
	// Slow unrelated rates keep each input inside its limits
	initial begin
		rf_clock_input = 1'b0;
		feedback_clock_input = 1'b0;
		reference_clock_input = 1'b0;
	end
	always #61 rf_clock_input = ~rf_clock_input;
	always #103 feedback_clock_input = ~feedback_clock_input;
	always #147 reference_clock_input = ~reference_clock_input;
endmodule // ddsc_far
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the clock divider and synthesizer core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value at %0t got %h exp %h", $time, g, e); end end
module testbench;
	logic        mclk = 1'b0, nrst = 1'b1, ce = 1'b1, io_update = 1'b0;
	logic        prof_we = 1'b0, cnt_on = 1'b0;
	logic [2:0]  prof_waddr = 3'h0, profile_select_pins = 3'h0;
	logic [47:0] prof_ftw = 48'h0;
	logic [13:0] prof_poff = 14'h0, p;
	logic [20:0] cfg = 21'h0;
	logic [1:0]  rdiv_sel, driver_src_sel, rdiv_ratio_q, driver_src_q;
	logic [3:0]  ref_div_m1, fb_div_m1, ref_div_q, fb_div_q;
	logic [2:0]  second_control_word, pump_scale_q;
	logic        rdiv_to_driver, surge_rise_en, surge_fall_en, surge_dflt_dis;
	logic        drv_int_rset, xtal_osc_en, rdiv_to_driver_q, surge_rise_q;
	logic        surge_fall_q, surge_dflt_dis_q, drv_int_rset_q, xtal_osc_q;
	logic        rf_clock_input, feedback_clock_input, reference_clock_input;
	logic        rf_div_clk_q, ref_div_clk_q, fb_div_clk_q, driver_clk_q;
	logic        sync_clk_q;
	logic [9:0]  converter_current_output;
	logic [9:0]  c[5];
	logic [6:0]  prv = 7'h0;
	logic [47:0] exp_q[$], got_q[$];
	int          err_count = 0, num_checks = 0, n[7];
	event        look;
	assign {rdiv_sel, rdiv_to_driver, ref_div_m1, fb_div_m1, second_control_word,
		driver_src_sel, surge_rise_en, surge_fall_en, surge_dflt_dis,
		drv_int_rset, xtal_osc_en} = cfg;
	wire [20:0] act = {rdiv_ratio_q, rdiv_to_driver_q, ref_div_q, fb_div_q,
		pump_scale_q, driver_src_q, surge_rise_q, surge_fall_q,
		surge_dflt_dis_q, drv_int_rset_q, xtal_osc_q};
	wire [6:0]  now = {rf_clock_input, reference_clock_input, feedback_clock_input,
		rf_div_clk_q, ref_div_clk_q, fb_div_clk_q, driver_clk_q};
	always #10 mclk = ~mclk;
	ddsc_core i_dut (.mclk, .nrst, .ce, .rdiv_sel, .rdiv_to_driver, .ref_div_m1,
		.fb_div_m1, .second_control_word, .driver_src_sel, .surge_rise_en,
		.surge_fall_en, .surge_dflt_dis, .drv_int_rset, .xtal_osc_en, .prof_we,
		.prof_waddr, .prof_ftw, .prof_poff, .profile_select_pins, .io_update,
		.rf_clock_input, .feedback_clock_input, .reference_clock_input,
		.rdiv_ratio_q, .rdiv_to_driver_q, .ref_div_q, .fb_div_q, .pump_scale_q,
		.driver_src_q, .surge_rise_q, .surge_fall_q, .surge_dflt_dis_q,
		.drv_int_rset_q, .xtal_osc_q, .rf_div_clk_q, .ref_div_clk_q,
		.fb_div_clk_q, .driver_clk_q, .sync_clk_q, .converter_current_output);
	ddsc_far i_far (.rf_clock_input, .feedback_clock_input, .reference_clock_input);
	// Rising edges of raw and divided clocks while a window is open
	always @(posedge mclk) begin
		for (int i = 0; i < 7; i++)
			if (cnt_on && now[i] && !prv[i]) n[i]++;
		prv <= now;
	end
	always @(look) begin
		logic [47:0] g, e;
		while (exp_q.size() > 0) begin
			g = got_q.pop_front();
			e = exp_q.pop_front();
			`CHK(g, e)
		end
	end
	function automatic bit near(int raw, int dv, int r);
		return dv * r - raw <= r && raw - dv * r <= r;
	endfunction
	task note(input [47:0] e, input [47:0] g);
		exp_q.push_back(e);
		got_q.push_back(g);
		-> look;
	endtask
	task upd(input [2:0] s);
		@(negedge mclk);
		profile_select_pins = s;
		io_update = 1'b1;
		repeat (9) @(negedge mclk);
		io_update = 1'b0;
		repeat (8) @(negedge mclk);
	endtask
	task wp(input [2:0] a, input [47:0] f, input [13:0] o);
		@(negedge mclk);
		{prof_we, prof_waddr, prof_ftw, prof_poff} = {1'b1, a, f, o};
		@(negedge mclk);
		prof_we = 1'b0;
	endtask
	task end_sim;
		#1;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#1_000_000;
		err_count++;
		end_sim;
	end
	initial begin
		// A real falling edge, so the asynchronous reset takes hold
		#2 nrst = 1'b0;
		void'($urandom(32'h90eb4eb4));
		repeat (8) @(negedge mclk);
		note(48'h200, converter_current_output);
		note(48'h040020, act);
		nrst = 1'b1;
		p = 14'($urandom);
		for (int k = 0; k < 8; k++)
			wp(3'(k), 48'h0, p ^ (k[0] ? 14'h2000 : 14'h0));
		repeat (6) begin
			cfg = 21'($urandom);
			upd(3'h0);
			note(cfg, act);
		end
		$display("test config done");
		for (int i = 0; i < 4; i++) begin
			cfg = 21'($urandom);
			cfg[20:19] = 2'(i);
			cfg[17:14] = i == 0 ? 4'h0 : 4'hf;
			cfg[6:5] = 2'(i);
			upd(3'h0);
			n = '{default: 0};
			cnt_on = 1'b1;
			repeat (1200) @(negedge mclk);
			cnt_on = 1'b0;
			note(1, near(n[6], n[3], 1 << i));
			note(1, near(n[5], n[2], cfg[17:14] + 1));
			note(1, near(n[4], n[1], cfg[13:10] + 1));
			if (i == 3) note(0, n[0]);
			else note(1, near(i == 2 ? n[4] : n[6], n[0],
				i == 1 && cfg[18] ? 2 : 1));
		end
		$display("test dividers done");
		for (int k = 0; k < 8; k++) begin
			upd(3'(k));
			c[k[0]] = converter_current_output;
			if (k[0]) note(10'h3ff, c[0] + c[1]);
		end
		wp(3'h0, 48'h4000_0000_0000, 14'h0);
		wp(3'h1, 48'h8000_0000_0000, 14'h0);
		wp(3'h2, 48'hffff_ffff_ffff, 14'h0);
		for (int k = 0; k < 3; k++) begin
			upd(3'(k));
			for (int j = 0; j < 5; j++) begin
				c[j] = converter_current_output;
				@(negedge mclk);
			end
			note(c[0], c[k == 0 ? 4 : 2]);
			note(10'h3ff, c[0] + c[k == 0 ? 2 : 1]);
		end
		$display("test synthesizer done");
		end_sim;
	end
endmodule // testbench
bind ddsc_core ddsc_chk i_chk (.mclk, .nrst, .io_update, .rdiv_sel,
	.rdiv_to_driver, .ref_div_m1, .fb_div_m1, .second_control_word,
	.driver_src_sel, .rdiv_ratio_q, .rdiv_to_driver_q, .ref_div_q, .fb_div_q,
	.pump_scale_q, .driver_src_q, .driver_clk_q, .sync_clk_q,
	.converter_current_output);
`default_nettype wire
